/* core/cmd_skid_buffer.sv */
`timescale 1ns/1ps
// Two-entry buffer; entry 0 is the head and drives the output directly
module cmd_skid_buffer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire dac_word_pkg::dac_cmd_t in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output dac_word_pkg::dac_cmd_t out_data_o
);
    dac_word_pkg::dac_cmd_t entry_reg [2];
    dac_word_pkg::dac_cmd_t entry_next [2];
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic push;
    logic pop;
    logic valid_reg;
    logic valid_next;

    // Ready stays honest: only when a slot is free
    always_comb begin
        push = in_valid_i && (count_reg != 2'h2);
        pop = out_ready_i && (count_reg != 2'h0);
        entry_next[0] = entry_reg[0];
        entry_next[1] = entry_reg[1];
        count_next = count_reg;
        if (pop) begin
            entry_next[0] = entry_reg[1];
        end
        if (push) begin
            if (count_reg == 2'h0 || (count_reg == 2'h1 && pop)) begin
                entry_next[0] = in_data_i;
            end else begin
                entry_next[pop ? 0 : 1] = in_data_i;
            end
        end
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
        // Valid gets its own flop so the port is driven straight from a register
        valid_next = (count_next != 2'h0);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            entry_reg[0] <= dac_word_pkg::CMD_RESET;
            entry_reg[1] <= dac_word_pkg::CMD_RESET;
            count_reg <= 2'h0;
            valid_reg <= 1'b0;
        end else begin
            entry_reg[0] <= entry_next[0];
            entry_reg[1] <= entry_next[1];
            count_reg <= count_next;
            valid_reg <= valid_next;
        end
    end

    assign in_ready_o = (count_reg != 2'h2);
    assign out_valid_o = valid_reg;
    assign out_data_o = entry_reg[0];

endmodule : cmd_skid_buffer

/* core/dac_serial_input_word_decoder.sv */
`timescale 1ns/1ps
// Function
// - A frame counts only when exactly 24 bits arrived before frame end.
// - Bits enter MSB first; each serial clock fall shifts left.
// - Fixed fields: 23 direction, 22 reserved, 21-19 register, 18-16 channel, 15-0 data.
// - Register select 000 DAC, 001 range, 010 power, 011 control.
// - Reads and writes reach every register; range is kept for readback here.
// - Bipolar twos-complement 12-bit codes map 7ff top, 000 mid, 800 bottom.
// - Unipolar codes are straight binary, 000 zero, fff full scale less a step.
module dac_serial_input_word_decoder (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic serial_clk_i,
    input wire logic frame_sync_n_i,
    input wire logic serial_data_in_i,
    input wire logic offset_binary_i,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output dac_word_pkg::dac_cmd_t cmd_o,
    output logic frame_error_o,
    output logic overrun_o,
    output logic [11:0] range_readback_o
);
    // Reset release
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Pin synchronisers; stage 1 feeds only stage 2
    logic [2:0] sclk_sync_reg;
    logic [2:0] sync_sync_reg;
    logic [2:0] serial_data_in_sync_reg;
    logic sclk_stable_reg;
    logic sclk_stable_next;
    logic sync_stable_reg;
    logic sync_stable_next;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync_reg <= 3'h0;
            sync_sync_reg <= 3'h7;
            serial_data_in_sync_reg <= 3'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clk_i};
            sync_sync_reg <= {sync_sync_reg[1:0], frame_sync_n_i};
            serial_data_in_sync_reg <= {serial_data_in_sync_reg[1:0], serial_data_in_i};
        end
    end

    // A pin change counts once stages two and three agree
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;

    always_comb begin
        sclk_stable_next = sclk_stable_reg;
        sync_stable_next = sync_stable_reg;
        if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
            sclk_stable_next = sclk_sync_reg[2];
        end
        if (sync_sync_reg[1] == sync_sync_reg[2]) begin
            sync_stable_next = sync_sync_reg[2];
        end
        sclk_fall = sclk_stable_reg && !sclk_stable_next;
        sync_fall = sync_stable_reg && !sync_stable_next;
        sync_rise = !sync_stable_reg && sync_stable_next;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_stable_reg <= 1'b0;
            sync_stable_reg <= 1'b1;
        end else begin
            sclk_stable_reg <= sclk_stable_next;
            sync_stable_reg <= sync_stable_next;
        end
    end

    // Channel decode, used for range updates and for the command
    function automatic logic [3:0] ch_decode(input logic [2:0] addr);
        unique case (addr)
            dac_word_pkg::CH_A: ch_decode = 4'h1;
            dac_word_pkg::CH_B: ch_decode = 4'h2;
            dac_word_pkg::CH_C: ch_decode = 4'h4;
            dac_word_pkg::CH_D: ch_decode = 4'h8;
            dac_word_pkg::CH_ALL: ch_decode = 4'hf;
            default: ch_decode = 4'h0;
        endcase
    endfunction : ch_decode

    function automatic dac_word_pkg::reg_sel_t reg_decode(input logic [2:0] sel);
        unique case (sel)
            dac_word_pkg::REG_DAC: reg_decode = dac_word_pkg::SEL_DAC;
            dac_word_pkg::REG_RANGE: reg_decode = dac_word_pkg::SEL_RANGE;
            dac_word_pkg::REG_POWER: reg_decode = dac_word_pkg::SEL_POWER;
            dac_word_pkg::REG_CTRL: reg_decode = dac_word_pkg::SEL_CTRL;
            default: reg_decode = dac_word_pkg::SEL_NONE;
        endcase
    endfunction : reg_decode

    function automatic logic is_bipolar(input logic [2:0] range);
        is_bipolar = (range == dac_word_pkg::RANGE_BIP5) || (range == dac_word_pkg::RANGE_BIP10)
            || (range == dac_word_pkg::RANGE_BIP10_8);
    endfunction : is_bipolar

    // Frame assembly
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic in_frame_reg;
    logic in_frame_next;
    logic frame_done;
    logic frame_error_reg;
    logic frame_error_next;

    always_comb begin
        shift_next = shift_reg;
        count_next = count_reg;
        in_frame_next = in_frame_reg;
        frame_done = 1'b0;
        frame_error_next = 1'b0;
        if (sync_fall) begin
            in_frame_next = 1'b1;
            count_next = 5'h00;
        end else if (in_frame_reg && sclk_fall) begin
            shift_next = {shift_reg[22:0], serial_data_in_sync_reg[2]};
            if (count_reg != dac_word_pkg::CNT_SAT) begin
                count_next = count_reg + 5'h01;
            end
        end
        if (in_frame_reg && sync_rise) begin
            in_frame_next = 1'b0;
            frame_done = (count_reg == dac_word_pkg::FRAME_BITS_CNT);
            frame_error_next = !frame_done;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= dac_word_pkg::SHIFT_RESET;
            count_reg <= 5'h00;
            in_frame_reg <= 1'b0;
            frame_error_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            count_reg <= count_next;
            in_frame_reg <= in_frame_next;
            frame_error_reg <= frame_error_next;
        end
    end

    // Per-channel range store; it decides bipolar versus unipolar coding
    logic [2:0] range_reg [dac_word_pkg::NUM_CH];
    logic [2:0] range_next [dac_word_pkg::NUM_CH];
    logic [3:0] frame_mask;
    logic [2:0] frame_ch;
    dac_word_pkg::reg_sel_t frame_target;
    logic range_write;

    assign frame_ch = shift_reg[dac_word_pkg::CH_MSB:dac_word_pkg::CH_LSB];
    assign frame_mask = ch_decode(frame_ch);
    assign frame_target = reg_decode(shift_reg[dac_word_pkg::REG_MSB:dac_word_pkg::REG_LSB]);
    assign range_write = frame_done && !shift_reg[dac_word_pkg::RW_POS]
        && (frame_target == dac_word_pkg::SEL_RANGE);

    genvar gi;
    generate
        for (gi = 0; gi < dac_word_pkg::NUM_CH; gi++) begin : g_range
            always_comb begin
                range_next[gi] = range_reg[gi];
                if (range_write && frame_mask[gi]) begin
                    range_next[gi] = shift_reg[2:0];
                end
            end
            always_ff @(posedge ref_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    range_reg[gi] <= dac_word_pkg::RANGE_RESET;
                end else begin
                    range_reg[gi] <= range_next[gi];
                end
            end
        end
    endgenerate

    // Build the command; a word held back by a stalled buffer waits one slot
    dac_word_pkg::dac_cmd_t frame_cmd;
    dac_word_pkg::dac_cmd_t pend_reg;
    dac_word_pkg::dac_cmd_t pend_next;
    logic pend_valid_reg;
    logic pend_valid_next;
    logic buf_ready;
    logic overrun_reg;
    logic overrun_next;
    logic [2:0] code_range;
    logic [11:0] code12;

    always_comb begin
        code12 = shift_reg[dac_word_pkg::DATA_MSB:dac_word_pkg::CODE12_LSB];
        code_range = range_reg[0];
        for (int i = dac_word_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (frame_mask[i]) begin
                code_range = range_reg[i];
            end
        end
        frame_cmd.read = shift_reg[dac_word_pkg::RW_POS];
        frame_cmd.reserved_bad = shift_reg[dac_word_pkg::RSVD_POS];
        frame_cmd.target = frame_target;
        frame_cmd.ch_mask = frame_mask;
        frame_cmd.data = shift_reg[dac_word_pkg::DATA_MSB:dac_word_pkg::DATA_LSB];
        // Level code counts up from the most negative output
        if (is_bipolar(code_range) && !offset_binary_i) begin
            frame_cmd.level_code = {~code12[11], code12[10:0]};
        end else begin
            frame_cmd.level_code = code12;
        end
        pend_next = pend_reg;
        pend_valid_next = pend_valid_reg;
        overrun_next = 1'b0;
        if (pend_valid_reg && buf_ready) begin
            pend_valid_next = 1'b0;
        end
        if (frame_done) begin
            overrun_next = pend_valid_reg && !buf_ready;
            pend_next = frame_cmd;
            pend_valid_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= dac_word_pkg::CMD_RESET;
            pend_valid_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            pend_valid_reg <= pend_valid_next;
            overrun_reg <= overrun_next;
        end
    end

    cmd_skid_buffer u_buf (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .in_valid_i(pend_valid_reg),
        .in_ready_o(buf_ready),
        .in_data_i(pend_reg),
        .out_valid_o(cmd_valid_o),
        .out_ready_i(cmd_ready_i),
        .out_data_o(cmd_o)
    );

    assign frame_error_o = frame_error_reg;
    assign overrun_o = overrun_reg;
    assign range_readback_o = {range_reg[3], range_reg[2], range_reg[1], range_reg[0]};

endmodule : dac_serial_input_word_decoder

/* core/dac_word_pkg.sv */
package dac_word_pkg;

    // Frame geometry
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [4:0] FRAME_BITS_CNT = 5'h18;
    localparam logic [4:0] CNT_SAT = 5'h1f;
    localparam int RW_POS = 23;
    localparam int RSVD_POS = 22;
    localparam int REG_MSB = 21;
    localparam int REG_LSB = 19;
    localparam int CH_MSB = 18;
    localparam int CH_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 0;
    localparam int CODE12_LSB = 4;

    // Register select codes
    localparam logic [2:0] REG_DAC = 3'h0;
    localparam logic [2:0] REG_RANGE = 3'h1;
    localparam logic [2:0] REG_POWER = 3'h2;
    localparam logic [2:0] REG_CTRL = 3'h3;

    // Channel address codes
    localparam logic [2:0] CH_A = 3'h0;
    localparam logic [2:0] CH_B = 3'h1;
    localparam logic [2:0] CH_C = 3'h2;
    localparam logic [2:0] CH_D = 3'h3;
    localparam logic [2:0] CH_ALL = 3'h4;
    localparam int NUM_CH = 4;

    // Output range codes that are bipolar, and the range after reset
    localparam logic [2:0] RANGE_BIP5 = 3'h3;
    localparam logic [2:0] RANGE_BIP10 = 3'h4;
    localparam logic [2:0] RANGE_BIP10_8 = 3'h5;
    localparam logic [2:0] RANGE_RESET = 3'h0;

    localparam logic [23:0] SHIFT_RESET = 24'h000000;

    typedef enum logic [2:0] {
        SEL_DAC,
        SEL_RANGE,
        SEL_POWER,
        SEL_CTRL,
        SEL_NONE
    } reg_sel_t;

    typedef struct packed {
        logic read;
        logic reserved_bad;
        reg_sel_t target;
        logic [3:0] ch_mask;
        logic [15:0] data;
        logic [11:0] level_code;
    } dac_cmd_t;

    localparam dac_cmd_t CMD_RESET = '0;

endpackage : dac_word_pkg

/* verif/dac_word_chk.sv */
`timescale 1ns/1ps
// Port-level checks on the serial word decoder
module dac_word_chk (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic frame_sync_n_i,
    input wire logic offset_binary_i,
    input wire logic cmd_valid_o,
    input wire logic cmd_ready_i,
    input wire dac_word_pkg::dac_cmd_t cmd_o,
    input wire logic frame_error_o,
    input wire logic overrun_o
);
    logic sync_reg;
    logic [4:0] since_reg;
    logic [4:0] since_next;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Cycles since the frame pin rose; saturates so an old frame never matches
    always_comb begin
        since_next = (since_reg == 5'h1f) ? since_reg : since_reg + 5'h01;
        if (frame_sync_n_i && !sync_reg) since_next = 5'h00;
    end
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_reg <= 1'b1;
            since_reg <= 5'h1f;
        end else begin
            sync_reg <= frame_sync_n_i;
            since_reg <= since_next;
        end
    end
    property p_valid_hold;
        cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_o);
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("word lost before taken");
    property p_err_pulse;
        frame_error_o |=> !frame_error_o;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("error pulse too long");
    property p_ovr_pulse;
        overrun_o |=> !overrun_o;
    endproperty
    a_ovr_pulse: assert property (p_ovr_pulse) else $error("overrun pulse too long");
    property p_err_timing;
        frame_error_o |-> since_reg inside {[5'h01:5'h07]};
    endproperty
    a_err_timing: assert property (p_err_timing) else $error("error not tied to frame end");
    property p_word_timing;
        $rose(cmd_valid_o) |-> since_reg inside {[5'h03:5'h09]};
    endproperty
    a_word_timing: assert property (p_word_timing) else $error("word not tied to frame end");
    property p_level_bits;
        cmd_valid_o |-> cmd_o.level_code[10:0] == cmd_o.data[14:4];
    endproperty
    a_level_bits: assert property (p_level_bits) else $error("code field misplaced");
    property p_level_msb;
        cmd_valid_o && offset_binary_i |-> cmd_o.level_code[11] == cmd_o.data[15];
    endproperty
    a_level_msb: assert property (p_level_msb) else $error("offset binary code altered");
    property p_mask_legal;
        cmd_valid_o |-> cmd_o.ch_mask inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    endproperty
    a_mask_legal: assert property (p_mask_legal) else $error("channel mask malformed");
    c_take: cover property (cmd_valid_o && cmd_ready_i);
    c_err: cover property (frame_error_o);
    c_ovr: cover property (overrun_o);
endmodule : dac_word_chk

bind dac_serial_input_word_decoder dac_word_chk chk_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .frame_sync_n_i(frame_sync_n_i), .offset_binary_i(offset_binary_i), .cmd_valid_o(cmd_valid_o),
    .cmd_ready_i(cmd_ready_i), .cmd_o(cmd_o), .frame_error_o(frame_error_o), .overrun_o(overrun_o));

/* verif/host_serial_model.sv */
`timescale 1ns/1ps
// Host serial port; clock idles high, data line toggles once released
module host_serial_model (
    input wire logic ref_clk_i,
    input wire logic go_i,
    input wire logic [23:0] word_i,
    input wire logic [4:0] nbits_i,
    input wire logic [3:0] half_i,
    output logic serial_clk_o,
    output logic frame_sync_n_o,
    output logic serial_data_o,
    output logic busy_o
);
    // One frame per go; every phase lasts half_i ref clocks
    initial begin
        serial_clk_o = 1'b1;
        frame_sync_n_o = 1'b1;
        serial_data_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge ref_clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                frame_sync_n_o <= 1'b0;
                for (int i = 0; i < int'(nbits_i); i++) begin
                    serial_data_o <= (i < 24) ? word_i[23 - i] : 1'b0;
                    repeat (half_i) @(posedge ref_clk_i);
                    serial_clk_o <= 1'b0;
                    repeat (half_i) @(posedge ref_clk_i);
                    serial_clk_o <= 1'b1;
                end
                repeat (half_i) @(posedge ref_clk_i);
                frame_sync_n_o <= 1'b1;
                serial_data_o <= ~serial_data_o; // No stale bit after release
                repeat (half_i) @(posedge ref_clk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule : host_serial_model

/* verif/test_dac_serial_input_word_decoder.sv */
`timescale 1ns/1ps
module test_dac_serial_input_word_decoder;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic go = 1'b0;
    logic [23:0] word = 24'h000000;
    logic [4:0] nbits = 5'h18;
    logic [3:0] half = 4'h3;
    logic offset_binary_i = 1'b0;
    logic cmd_ready_i = 1'b0;
    logic sclk, sync_n, sdata, busy, cmd_valid_o, frame_error_o, overrun_o;
    logic [11:0] range_readback_o;
    dac_word_pkg::dac_cmd_t cmd_o;
    dac_word_pkg::dac_cmd_t bq [4];
    logic [2:0] rng [4] = '{3'h0, 3'h0, 3'h0, 3'h0};
    int error_cnt = 0;
    int n_compared = 0;
    int n_err = 0;
    int n_ovr = 0;
    host_serial_model host_u (.ref_clk_i(ref_clk_i), .go_i(go), .word_i(word), .nbits_i(nbits), .half_i(half),
        .serial_clk_o(sclk), .frame_sync_n_o(sync_n), .serial_data_o(sdata), .busy_o(busy));
    dac_serial_input_word_decoder dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .serial_clk_i(sclk),
        .frame_sync_n_i(sync_n), .serial_data_in_i(sdata), .offset_binary_i(offset_binary_i),
        .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i), .cmd_o(cmd_o), .frame_error_o(frame_error_o),
        .overrun_o(overrun_o), .range_readback_o(range_readback_o));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // Pulses last one cycle, so they are tallied rather than polled
    always @(posedge ref_clk_i) begin
        n_err += (frame_error_o === 1'b1);
        n_ovr += (overrun_o === 1'b1);
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Range is looked up before the frame, as the decoder sees it then
    function automatic dac_word_pkg::dac_cmd_t expect_cmd(input logic [23:0] w);
        dac_word_pkg::dac_cmd_t c;
        logic [2:0] r;
        c = dac_word_pkg::CMD_RESET;
        c.read = w[23];
        c.reserved_bad = w[22];
        c.target = (w[21:19] < 3'h4) ? dac_word_pkg::reg_sel_t'(w[21:19]) : dac_word_pkg::SEL_NONE;
        c.ch_mask = (w[18:16] == 3'h4) ? 4'hf : (w[18] ? 4'h0 : 4'h1 << w[17:16]);
        c.data = w[15:0];
        r = rng[w[17:16]];
        c.level_code = w[15:4] ^ {(r inside {3'h3, 3'h4, 3'h5}) && !offset_binary_i, 11'h000};
        return c;
    endfunction : expect_cmd
    task automatic send(input logic [23:0] w, input logic [4:0] n, input logic [3:0] h);
        @(posedge ref_clk_i);
        go <= 1'b1;
        word <= w;
        nbits <= n;
        half <= h;
        @(posedge ref_clk_i);
        go <= 1'b0;
        @(posedge ref_clk_i);
        for (int t = 0; t < 2000 && busy !== 1'b0; t++) @(posedge ref_clk_i);
        check(busy, 1'b0);
    endtask : send
    task automatic take(input dac_word_pkg::dac_cmd_t e);
        for (int t = 0; t < 100 && cmd_valid_o !== 1'b1; t++) @(posedge ref_clk_i);
        check(cmd_valid_o, 1'b1);
        check(cmd_o, e);
        cmd_ready_i <= 1'b1;
        @(posedge ref_clk_i);
        cmd_ready_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : take
    task automatic xfer(input logic [23:0] w, input logic [3:0] h);
        dac_word_pkg::dac_cmd_t e;
        e = expect_cmd(w);
        send(w, 5'h18, h);
        take(e);
        for (int i = 0; i < 4; i++) begin
            if (!w[23] && w[21:19] == 3'h1 && e.ch_mask[i]) rng[i] = w[2:0];
        end
        repeat (3) @(posedge ref_clk_i);
        check(range_readback_o, {rng[3], rng[2], rng[1], rng[0]});
    endtask : xfer
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    // Tests need about 10,000 cycles; the limit leaves ample margin
    initial begin
        #400000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        check(range_readback_o, 12'h000);
        // Ranges: A unipolar, B to D bipolar; then a read that must not alter them
        for (int c = 0; c < 4; c++) xfer({5'h01, 3'(c), 13'h0000, 3'(c + 2)}, 4'h3);
        xfer(24'h8c0007, 4'h7);
        // Data codes on every channel and on all, prompt and slow host, both formats
        for (int ob = 0; ob < 2; ob++) begin
            offset_binary_i <= ob[0];
            @(posedge ref_clk_i);
            for (int a = 0; a < 10; a++) xfer({5'h00, 3'(a / 2), a[0] ? 16'h800a : 16'h7ff5}, 4'(3 + 4 * (a % 2)));
        end
        for (int s = 0; s < 8; s++) xfer({s[0], 1'b0, 3'(s), 3'h3, 16'h0005}, 4'h3);
        xfer(24'h412345, 4'h3);
        // Short and long frames are dropped
        n_err = 0;
        send(24'h00abcd, 5'h17, 4'h3);
        send(24'h00abcd, 5'h19, 4'h3);
        repeat (10) @(posedge ref_clk_i);
        check(n_err, 2);
        check(cmd_valid_o, 1'b0);
        // Stalled consumer: fourth frame replaces the pending word
        n_ovr = 0;
        for (int i = 0; i < 4; i++) begin
            bq[i] = expect_cmd({5'h00, 3'(i), 16'h1230 + 16'(i)});
            send({5'h00, 3'(i), 16'h1230 + 16'(i)}, 5'h18, 4'h3);
        end
        repeat (10) @(posedge ref_clk_i);
        check(n_ovr, 1);
        take(bq[0]);
        take(bq[1]);
        take(bq[3]);
        check(cmd_valid_o, 1'b0);
        // Reset in mid-run clears the stored ranges
        rstn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        check(range_readback_o, 12'h000);
        rstn_i <= 1'b1;
        rng = '{3'h0, 3'h0, 3'h0, 3'h0};
        repeat (10) @(posedge ref_clk_i);
        xfer(24'h0c0004, 4'h3);
        end_of_test();
    end
endmodule : test_dac_serial_input_word_decoder
